// [design/hms_homing_sequencer.sv]
// Homing method sequencer: runs one homing search per start request
// What this block does
// RQ1: Method 9: positive, first index after rising.
// RQ2: Method 10: positive, index after falling edge.
// RQ3: Method 11: negative, index after falling edge.
// RQ4: Method 12: negative, index after rising edge.
// RQ5: Methods 13, 14: negative, far-side index.
// RQ6: Far side: 13 rising, 14 falling edge.
// RQ7: Methods 25-30: qualifying edge itself is home.
// RQ8: Method 33: negative, first index is home.
// RQ9: Method 34: positive, first index is home.
// RQ10: Latch position, stop, flag homing done.
`timescale 1ns/1ps
module hms_homing_sequencer
  import hms_pkg::*;
#(
  parameter int POS_W = HMS_POS_W
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    start,
  input  wire logic [HMS_METHOD_W-1:0] method,
  input  wire logic [POS_W-1:0]        pos_in,
  input  wire logic                    home_sw,
  input  wire logic                    index_z,
  output logic                         move_pos,
  output logic                         move_neg,
  output logic                         decel,
  output logic                         busy,
  output logic                         home_done,
  output logic                         home_fault,
  output logic [POS_W-1:0]             home_pos
);
  logic                    sw_lvl;
  logic                    idx_lvl;
  logic                    sw_prev_reg;
  logic                    idx_prev_reg;
  logic                    sw_rise;
  logic                    sw_fall;
  logic                    idx_rise;
  logic                    qual_edge;

  logic                    dec_ok;
  logic                    dec_pos;
  logic                    dec_sw;
  logic                    dec_rise;
  logic                    dec_far;
  logic                    dec_dhome;
  logic [HMS_METHOD_W-1:0] dec_base;

  hms_state_t              state_reg, state_next;
  logic [HMS_METHOD_W-1:0] meth_reg, meth_next;
  logic                    cfg_rise_reg, cfg_rise_next;
  logic                    cfg_far_reg, cfg_far_next;
  logic                    cfg_dhome_reg, cfg_dhome_next;
  logic                    move_pos_reg, move_pos_next;
  logic                    move_neg_reg, move_neg_next;
  logic                    decel_reg, decel_next;
  logic                    busy_reg, busy_next;
  logic                    done_reg, done_next;
  logic                    fault_reg, fault_next;
  logic [POS_W-1:0]        home_pos_reg, home_pos_next;
  logic                    finish;

  hms_pin_sync u_sw_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (home_sw),
    .level (sw_lvl)
  );

  hms_pin_sync u_idx_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (index_z),
    .level (idx_lvl)
  );

  assign sw_rise   = sw_lvl & ~sw_prev_reg;
  assign sw_fall   = ~sw_lvl & sw_prev_reg;
  assign idx_rise  = idx_lvl & ~idx_prev_reg;
  assign qual_edge = cfg_rise_reg ? sw_rise : sw_fall;

  // Method decode
  always_comb begin
    dec_ok    = 1'b0;
    dec_pos   = 1'b0;
    dec_sw    = 1'b0;
    dec_rise  = 1'b0;
    dec_far   = 1'b0;
    dec_dhome = 1'b0;
    dec_base  = method;
    // RQ7 twin methods
    if (method >= (HMS_M_SW_FIRST + HMS_DHOME_OFS) &&
        method <= (HMS_M_SW_LAST + HMS_DHOME_OFS)) begin
      dec_base  = method - HMS_DHOME_OFS;
      dec_dhome = 1'b1;
    end
    unique case (dec_base)
      // RQ1 rising, positive
      HMS_M9: begin
        dec_ok   = 1'b1;
        dec_pos  = 1'b1;
        dec_rise = 1'b1;
      end
      // RQ2 falling, positive
      HMS_M10: begin
        dec_ok  = 1'b1;
        dec_pos = 1'b1;
      end
      // RQ3 falling, negative
      HMS_M11: begin
        dec_ok = 1'b1;
      end
      // RQ4 rising, negative
      HMS_M12: begin
        dec_ok   = 1'b1;
        dec_rise = 1'b1;
      end
      // RQ5 RQ6 far side rising
      HMS_M13: begin
        dec_ok   = 1'b1;
        dec_rise = 1'b1;
        dec_far  = 1'b1;
      end
      // RQ5 RQ6 far side falling
      HMS_M14: begin
        dec_ok  = 1'b1;
        dec_far = 1'b1;
      end
      // RQ8 index only, negative
      HMS_M_IDX_NEG: begin
        dec_ok = 1'b1;
      end
      // RQ9 index only, positive
      HMS_M_IDX_POS: begin
        dec_ok  = 1'b1;
        dec_pos = 1'b1;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
    dec_sw = dec_ok && (dec_base != HMS_M_IDX_NEG) && (dec_base != HMS_M_IDX_POS);
    dec_dhome = dec_dhome & dec_ok;
  end

  // Sequencer next state
  always_comb begin
    state_next     = state_reg;
    meth_next      = meth_reg;
    cfg_rise_next  = cfg_rise_reg;
    cfg_far_next   = cfg_far_reg;
    cfg_dhome_next = cfg_dhome_reg;
    move_pos_next  = move_pos_reg;
    move_neg_next  = move_neg_reg;
    decel_next     = decel_reg;
    busy_next      = busy_reg;
    done_next      = done_reg;
    fault_next     = fault_reg;
    home_pos_next  = home_pos_reg;
    finish         = 1'b0;
    unique case (state_reg)
      HMS_IDLE: begin
        if (start) begin
          meth_next  = method;
          done_next  = 1'b0;
          decel_next = 1'b0;
          fault_next = ~dec_ok;
          if (dec_ok) begin
            cfg_rise_next  = dec_rise;
            cfg_far_next   = dec_far;
            cfg_dhome_next = dec_dhome;
            move_pos_next  = dec_pos;
            move_neg_next  = ~dec_pos;
            busy_next      = 1'b1;
            state_next     = dec_sw ? HMS_SEARCH : HMS_INDEX;
          end
        end
      end
      HMS_SEARCH: begin
        // Switch engages: slow down
        if (sw_rise) begin
          decel_next = 1'b1;
        end
        if (qual_edge) begin
          // RQ7 edge is home
          if (cfg_dhome_reg) begin
            finish = 1'b1;
          end else begin
            // RQ5 RQ6 rising must still cross
            state_next = (cfg_far_reg && cfg_rise_reg) ? HMS_CROSS : HMS_INDEX;
          end
        end
      end
      HMS_CROSS: begin
        // RQ6 pass switch's far edge
        if (sw_rise | sw_fall) begin
          state_next = HMS_INDEX;
        end
      end
      HMS_INDEX: begin
        if (idx_rise) begin
          finish = 1'b1;
        end
      end
    endcase
    // RQ10 latch, stop, report
    if (finish) begin
      home_pos_next = pos_in;
      move_pos_next = 1'b0;
      move_neg_next = 1'b0;
      busy_next     = 1'b0;
      done_next     = 1'b1;
      state_next    = HMS_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= HMS_IDLE;
      meth_reg      <= HMS_METHOD_RST;
      cfg_rise_reg  <= 1'b0;
      cfg_far_reg   <= 1'b0;
      cfg_dhome_reg <= 1'b0;
      move_pos_reg  <= 1'b0;
      move_neg_reg  <= 1'b0;
      decel_reg     <= 1'b0;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      fault_reg     <= 1'b0;
      home_pos_reg  <= '0;
      sw_prev_reg   <= 1'b0;
      idx_prev_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      meth_reg      <= meth_next;
      cfg_rise_reg  <= cfg_rise_next;
      cfg_far_reg   <= cfg_far_next;
      cfg_dhome_reg <= cfg_dhome_next;
      move_pos_reg  <= move_pos_next;
      move_neg_reg  <= move_neg_next;
      decel_reg     <= decel_next;
      busy_reg      <= busy_next;
      done_reg      <= done_next;
      fault_reg     <= fault_next;
      home_pos_reg  <= home_pos_next;
      sw_prev_reg   <= sw_lvl;
      idx_prev_reg  <= idx_lvl;
    end
  end

  assign move_pos   = move_pos_reg;
  assign move_neg   = move_neg_reg;
  assign decel      = decel_reg;
  assign busy       = busy_reg;
  assign home_done  = done_reg;
  assign home_fault = fault_reg;
  assign home_pos   = home_pos_reg;

  AST_M9_POSITIVE: assert property (@(posedge clk) disable iff (!rst_b) // RQ1
    busy_reg && meth_reg == HMS_M9 |-> move_pos_reg && !move_neg_reg)
    else $error("method 9 not moving positive");
  AST_M10_FALL_QUAL: assert property (@(posedge clk) disable iff (!rst_b) // RQ2
    state_reg == HMS_SEARCH && meth_reg == HMS_M10 && sw_rise |=> state_reg == HMS_SEARCH)
    else $error("method 10 qualified on rising edge");
  AST_M11_NEGATIVE: assert property (@(posedge clk) disable iff (!rst_b) // RQ3
    busy_reg && meth_reg == HMS_M11 |-> move_neg_reg && !move_pos_reg)
    else $error("method 11 not moving negative");
  AST_M12_RISE_INDEX: assert property (@(posedge clk) disable iff (!rst_b) // RQ4
    state_reg == HMS_SEARCH && meth_reg == HMS_M12 && sw_rise |=> state_reg == HMS_INDEX)
    else $error("method 12 did not seek index after rising edge");
  AST_M13_FAR_SIDE: assert property (@(posedge clk) disable iff (!rst_b) // RQ5
    state_reg == HMS_SEARCH && meth_reg == HMS_M13 && sw_rise |=> state_reg == HMS_CROSS)
    else $error("method 13 did not cross the switch");
  AST_M14_FALL_FAR: assert property (@(posedge clk) disable iff (!rst_b) // RQ6
    state_reg == HMS_SEARCH && meth_reg == HMS_M14 && sw_fall |=> state_reg == HMS_INDEX)
    else $error("method 14 not qualified by falling edge");
  AST_DHOME_NO_INDEX: assert property (@(posedge clk) disable iff (!rst_b) // RQ7
    state_reg == HMS_SEARCH && cfg_dhome_reg && qual_edge |=> done_reg && !busy_reg)
    else $error("decel point not taken as home");
  AST_M33_INDEX_NEG: assert property (@(posedge clk) disable iff (!rst_b) // RQ8
    busy_reg && meth_reg == HMS_M_IDX_NEG |-> move_neg_reg && state_reg == HMS_INDEX)
    else $error("method 33 not index search in negative direction");
  AST_M34_INDEX_POS: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
    busy_reg && meth_reg == HMS_M_IDX_POS |-> move_pos_reg && state_reg == HMS_INDEX)
    else $error("method 34 not index search in positive direction");
  AST_HOME_LATCH: assert property (@(posedge clk) disable iff (!rst_b) // RQ10
    state_reg == HMS_INDEX && idx_rise |=>
      home_pos_reg == $past(pos_in) && done_reg && !move_pos_reg && !move_neg_reg)
    else $error("home position not latched or motion not stopped");
endmodule : hms_homing_sequencer

// [design/hms_pkg.sv]
// Constants and types shared by the homing method sequencer
package hms_pkg;
  localparam int HMS_METHOD_W    = 6;
  localparam int HMS_POS_W       = 32;
  // Switch based methods kept in this block
  localparam logic [5:0] HMS_M_SW_FIRST = 6'h09;
  localparam logic [5:0] HMS_M9         = 6'h09;
  localparam logic [5:0] HMS_M10        = 6'h0a;
  localparam logic [5:0] HMS_M11        = 6'h0b;
  localparam logic [5:0] HMS_M12        = 6'h0c;
  localparam logic [5:0] HMS_M13        = 6'h0d;
  localparam logic [5:0] HMS_M14        = 6'h0e;
  localparam logic [5:0] HMS_M_SW_LAST  = 6'h0e;
  // Offset from a switch method to its decel-is-home twin
  localparam logic [5:0] HMS_DHOME_OFS  = 6'h10;
  localparam logic [5:0] HMS_M_IDX_NEG  = 6'h21;
  localparam logic [5:0] HMS_M_IDX_POS  = 6'h22;
  localparam logic [5:0] HMS_METHOD_RST = 6'h00;
  localparam logic       HMS_SYNC_RST   = 1'b0;

  typedef enum logic [1:0] {
    HMS_IDLE,
    HMS_SEARCH,
    HMS_CROSS,
    HMS_INDEX
  } hms_state_t;
endpackage : hms_pkg

// [design/hms_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module hms_pin_sync
  import hms_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  logic level_next;

  always_comb begin
    // Level moves only once stages two and three agree
    level_next = (ff2_reg == ff3_reg) ? ff3_reg : level_reg;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff1_reg   <= HMS_SYNC_RST;
      ff2_reg   <= HMS_SYNC_RST;
      ff3_reg   <= HMS_SYNC_RST;
      level_reg <= HMS_SYNC_RST;
    end else begin
      ff1_reg   <= pin;
      ff2_reg   <= ff1_reg;
      ff3_reg   <= ff2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule : hms_pin_sync

// [dv/hms_axis_model.sv]
// Axis model: moving position, two switch cams and index marks
`timescale 1ns/1ps
module hms_axis_model
#(
  parameter int STEP = 16
)
(
  input  wire logic        clk,
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        move_pos,
  input  wire logic        move_neg,
  output logic [31:0]      pos,
  output logic             home_sw,
  output logic             index_z
);
  int cnt = 0;
  initial pos = 32'h0c;
  // One count per STEP cycles keeps pos steady over the pin latency
  always @(posedge clk) begin
    cnt <= (cnt + 1) % STEP;
    if (load) begin
      pos <= load_val;
    end else if (cnt == 0 && move_pos) begin
      pos <= pos + 32'h1;
    end else if (cnt == 0 && move_neg) begin
      pos <= pos - 32'h1;
    end
  end
  // Main cam 20..43, short cam 4..9
  assign home_sw = (pos >= 32'h14 && pos <= 32'h2b) || (pos >= 32'h04 && pos <= 32'h09);
  // Index mark every eight counts
  assign index_z = (pos[2:0] == 3'h0);
endmodule : hms_axis_model

// [dv/hms_homing_sequencer_bench.sv]
// Self-checking bench for the homing method sequencer
`timescale 1ns/1ps
module hms_homing_sequencer_bench;
  import hms_pkg::*;
  typedef struct packed {logic f; logic d; logic [31:0] p;} hms_note_t;
  logic        clk = 1'b0, rst_b = 1'b0, start = 1'b0, load = 1'b0;
  logic [5:0]  method = 6'h00;
  logic [31:0] load_val = 32'h0c, pos, home_pos, seed = 32'h8a5cb5dd;
  logic        home_sw, index_z, move_pos, move_neg, decel, busy, home_done, home_fault;
  logic        tk, tk_q = 1'b0, d_q = 1'b0;
  logic [5:0]  bad_m [10] = '{6'h00, 6'h01, 6'h08, 6'h0f, 6'h10, 6'h11, 6'h18, 6'h1f,
                              6'h20, 6'h23};
  int          n_fail = 0, tests_run = 0;
  hms_note_t   q[$], pend;

  hms_homing_sequencer u_dut (.clk(clk), .rst_b(rst_b), .start(start), .method(method),
    .pos_in(pos), .home_sw(home_sw), .index_z(index_z), .move_pos(move_pos),
    .move_neg(move_neg), .decel(decel), .busy(busy), .home_done(home_done),
    .home_fault(home_fault), .home_pos(home_pos));
  hms_axis_model u_axis (.clk(clk), .load(load), .load_val(load_val), .move_pos(move_pos),
    .move_neg(move_neg), .pos(pos), .home_sw(home_sw), .index_z(index_z));

  initial forever #2 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", nm, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_pos(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask : cmp_pos

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic go(input logic [5:0] m);
    @(negedge clk);
    method = m;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : go

  task automatic run(input logic [5:0] m, input logic [31:0] p0, input logic dir,
                     input logic [31:0] hp, input logic dc);
    int k;
    @(negedge clk);
    load_val = p0;
    load = 1'b1;
    @(negedge clk);
    load = 1'b0;
    repeat (8) @(negedge clk);
    q.push_back({1'b0, dc, hp});
    go(m);
    cmp_bit("move_pos", dir, move_pos);
    cmp_bit("move_neg", ~dir, move_neg);
    // Start while busy must be ignored
    go(6'h00);
    k = 0;
    while (busy === 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    cmp_bit("busy", 1'b0, busy);
    cmp_bit("home_done", 1'b1, home_done);
    cmp_bit("stopped", 1'b0, move_pos | move_neg);
    $display("method %0d finished", m);
  endtask : run

  task automatic bad(input logic [5:0] m);
    q.push_back({1'b1, 1'b0, 32'h0});
    go(m);
    @(negedge clk);
    $display("method %0d refused", m);
  endtask : bad

  // Result watcher: pops the oldest note per accepted start
  initial forever begin
    @(posedge clk);
    tk = start & ~busy;
    #1;
    if (tk_q) begin
      pend = q.pop_front();
      cmp_bit("home_fault", pend.f, home_fault);
    end
    if (home_done && !d_q) begin
      cmp_pos("home_pos", pend.p, home_pos);
      cmp_bit("decel", pend.d, decel);
    end
    tk_q = tk;
    d_q = home_done;
  end

  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    foreach (bad_m[i]) bad(bad_m[i]);
    repeat (8) begin
      seed = xs(seed);
      bad({2'b11, seed[3:0]});
    end
    run(6'h09, 32'h0c, 1'b1, 32'h18, 1'b1);
    run(6'h0a, 32'h0c, 1'b1, 32'h30, 1'b1);
    run(6'h0b, 32'h34, 1'b0, 32'h10, 1'b1);
    run(6'h0c, 32'h34, 1'b0, 32'h28, 1'b1);
    run(6'h0d, 32'h34, 1'b0, 32'h10, 1'b1);
    run(6'h0e, 32'h34, 1'b0, 32'h10, 1'b1);
    run(6'h19, 32'h0c, 1'b1, 32'h14, 1'b1);
    run(6'h1a, 32'h0c, 1'b1, 32'h2c, 1'b1);
    run(6'h1b, 32'h34, 1'b0, 32'h13, 1'b1);
    run(6'h1c, 32'h34, 1'b0, 32'h2b, 1'b1);
    run(6'h1d, 32'h34, 1'b0, 32'h2b, 1'b1);
    run(6'h1e, 32'h34, 1'b0, 32'h13, 1'b1);
    run(6'h21, 32'h34, 1'b0, 32'h30, 1'b0);
    run(6'h22, 32'h0c, 1'b1, 32'h10, 1'b0);
    conclude();
  end

  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule : hms_homing_sequencer_bench
